// ---- tcspl_pkg.sv ----
// Shared constants, encodings and state layouts of the channel state and power logic.
// Assumes a 20 MHz APB clock and a front end that delivers one count per conversion.
package tcspl_pkg;

    localparam int MAX_CH = 4;
    localparam int CW = 16;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PM_TIMEOUT = 8'h08;
    localparam logic [7:0] ADDR_EVT_TIMEOUT = 8'h0c;
    localparam logic [7:0] ADDR_BETAS = 8'h10;
    localparam logic [7:0] ADDR_FAST_BETAS = 8'h14;
    localparam logic [7:0] ADDR_MAX_COUNT = 8'h18;
    localparam logic [7:0] ADDR_FAST_BAND = 8'h1c;
    localparam logic [7:0] ADDR_PROX_BASE = 8'h40;
    localparam logic [7:0] ADDR_TOUCH_BASE = 8'h44;
    localparam int PROX_STRIDE = 8;
    localparam logic [7:0] ADDR_DATA_BASE = 8'h80;
    localparam int DATA_STRIDE = 4;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RESEED_BIT = 3;
    localparam int CTRL_EXPIRY_LSB = 8;
    localparam int STATUS_MODE_LSB = 0;
    localparam int STATUS_NEAR_LSB = 8;
    localparam int STATUS_CONTACT_LSB = 12;
    localparam int PROX_THR_LSB = 0;
    localparam int PROX_ENTER_LSB = 16;
    localparam int PROX_EXIT_LSB = 20;
    localparam int PROX_LIN_BIT = 24;
    localparam int PROX_INV_BIT = 25;
    localparam int PROX_DUAL_BIT = 26;
    localparam int TOUCH_THR_LSB = 0;
    localparam int TOUCH_HYST_LSB = 16;
    localparam int BETA_CNT_NP_LSB = 0;
    localparam int BETA_CNT_LP_LSB = 8;
    localparam int BETA_LTA_NP_LSB = 16;
    localparam int BETA_LTA_LP_LSB = 24;
    localparam int FAST_NP_LSB = 0;
    localparam int FAST_LP_LSB = 8;
    localparam int DATA_LTA_LSB = 16;

    localparam logic [7:0] PM_TIMEOUT_RST = 8'h0a;
    localparam logic [15:0] EVT_TIMEOUT_RST = 16'h0000;
    localparam logic [31:0] BETAS_RST = 32'h40408080;
    localparam logic [15:0] FAST_BETAS_RST = 16'hc0c0;
    localparam logic [15:0] MAX_COUNT_RST = 16'hffff;
    localparam logic [15:0] FAST_BAND_RST = 16'h0040;
    localparam logic [26:0] PROX_CFG_RST = 27'h0220020;
    localparam logic [23:0] TOUCH_CFG_RST = 24'h100040;

    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES_DFLT = TICK_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        SEL_FULL, SEL_REDUCED, SEL_DEEPEST, SEL_HALT, SEL_AUTO, SEL_AUTO_NO_DEEPEST
    } tcspl_sel_t;

    typedef enum logic [1:0] {CUR_FULL, CUR_REDUCED, CUR_DEEPEST, CUR_HALT} tcspl_cur_t;

    typedef struct packed {
        tcspl_sel_t sel;
        logic reseed;
        logic [MAX_CH-1:0] expiry_off;
        logic halt_window;
        tcspl_cur_t cur;
        logic [7:0] pm_timeout;
        logic [7:0] idle_ticks;
        logic [31:0] tick_cnt;
        logic [15:0] evt_timeout;
        logic [31:0] betas;
        logic [15:0] fast_betas;
        logic [15:0] max_count;
        logic [15:0] fast_band;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic sensing_enable;
    } tcspl_top_t;

    typedef struct packed {
        logic [26:0] prox_cfg;
        logic [23:0] touch_cfg;
        logic [15:0] counts;
        logic [15:0] long_term_average;
        logic primed;
        logic near;
        logic contact;
        logic [3:0] db_cnt;
        logic [15:0] ev_cnt;
    } tcspl_chan_t;

    localparam tcspl_top_t TOP_RST = '{sel: SEL_FULL, cur: CUR_FULL,
        pm_timeout: PM_TIMEOUT_RST, evt_timeout: EVT_TIMEOUT_RST, betas: BETAS_RST,
        fast_betas: FAST_BETAS_RST, max_count: MAX_COUNT_RST, fast_band: FAST_BAND_RST,
        sensing_enable: 1'b1, default: '0};

    localparam tcspl_chan_t CHAN_RST = '{prox_cfg: PROX_CFG_RST, touch_cfg: TOUCH_CFG_RST,
        default: '0};

endpackage

// ---- tcspl_chan.sv ----
// One sensing channel: count limit, linearisation, filters, reference and state logic.
// Assumes sample_valid pulses once per completed conversion of this channel.
`timescale 1ns/1ps
`default_nettype none
module tcspl_chan
    import tcspl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_valid,
    input wire logic [15:0] raw,
    input wire logic wr_prox,
    input wire logic wr_touch,
    input wire logic [31:0] wdata,
    input wire logic low_rate,
    input wire logic [31:0] betas,
    input wire logic [15:0] fast_betas,
    input wire logic [15:0] max_count,
    input wire logic [15:0] fast_band,
    input wire logic [15:0] evt_timeout,
    input wire logic expiry_off,
    input wire logic reseed,
    output logic [26:0] prox_cfg,
    output logic [23:0] touch_cfg,
    output logic [15:0] counts,
    output logic [15:0] long_term_average,
    output logic near,
    output logic contact
);

    tcspl_chan_t st;
    tcspl_chan_t next_st;

    // New value moves toward the sample by beta/256 of the gap.
    function automatic logic [15:0] iir(input logic [15:0] old_v, input logic [15:0] new_v,
                                        input logic [7:0] beta);
        logic signed [16:0] diff;
        logic signed [26:0] prod;
        diff = $signed({1'b0, new_v}) - $signed({1'b0, old_v});
        prod = diff * $signed({1'b0, beta});
        return old_v + 16'(prod >>> 8);
    endfunction

    logic [15:0] clamped, meas, filt;
    logic signed [17:0] dir, mag, ext, thr_p, thr_t, thr_h;
    logic prox_hit, touch_hit, fast_hit, expire;
    logic [7:0] cnt_beta, lta_beta, fast_beta;

    always_comb begin
        next_st = st;
        clamped = (raw > max_count) ? max_count : raw;
        meas = st.prox_cfg[PROX_LIN_BIT] ? ~clamped : clamped;
        cnt_beta = low_rate ? betas[BETA_CNT_LP_LSB +: 8] : betas[BETA_CNT_NP_LSB +: 8];
        lta_beta = low_rate ? betas[BETA_LTA_LP_LSB +: 8] : betas[BETA_LTA_NP_LSB +: 8];
        fast_beta = low_rate ? fast_betas[FAST_LP_LSB +: 8] : fast_betas[FAST_NP_LSB +: 8];
        filt = st.primed ? iir(st.counts, meas, cnt_beta) : meas;
        dir = $signed({2'b0, st.long_term_average}) - $signed({2'b0, filt});
        if (st.prox_cfg[PROX_INV_BIT]) begin
            dir = -dir;
        end
        mag = (dir < 0) ? -dir : dir;
        ext = st.prox_cfg[PROX_DUAL_BIT] ? mag : dir;
        thr_p = $signed({2'b0, st.prox_cfg[PROX_THR_LSB +: 16]});
        thr_t = $signed({2'b0, st.touch_cfg[TOUCH_THR_LSB +: 16]});
        thr_h = thr_t - $signed({10'b0, st.touch_cfg[TOUCH_HYST_LSB +: 8]});
        prox_hit = ext > thr_p;
        touch_hit = st.contact ? !(ext < thr_h) : (ext > thr_t);
        fast_hit = (-dir) > $signed({2'b0, fast_band});
        expire = (st.near || st.contact) && !expiry_off && (evt_timeout != 16'h0000)
                 && ((st.ev_cnt + 16'h0001) >= evt_timeout);
        if (wr_prox) begin
            next_st.prox_cfg = wdata[26:0];
        end
        if (wr_touch) begin
            next_st.touch_cfg = wdata[23:0];
        end
        if (sample_valid) begin
            next_st.counts = filt;
            next_st.primed = 1'b1;
            if (!st.primed) begin
                next_st.long_term_average = meas;
            end else if (expire) begin
                next_st.long_term_average = filt;
                next_st.near = 1'b0;
                next_st.contact = 1'b0;
                next_st.db_cnt = '0;
                next_st.ev_cnt = '0;
            end else begin
                if (!(st.near || st.contact)) begin
                    next_st.long_term_average = iir(st.long_term_average, filt, fast_hit ? fast_beta : lta_beta);
                end
                if (prox_hit != st.near) begin
                    if (st.db_cnt >= (st.near ? st.prox_cfg[PROX_EXIT_LSB +: 4]
                                              : st.prox_cfg[PROX_ENTER_LSB +: 4])) begin
                        next_st.near = prox_hit;
                        next_st.db_cnt = '0;
                    end else begin
                        next_st.db_cnt = st.db_cnt + 4'h1;
                    end
                end else begin
                    next_st.db_cnt = '0;
                end
                next_st.contact = touch_hit;
                next_st.ev_cnt = (st.near || st.contact) ? st.ev_cnt + 16'h0001 : 16'h0000;
            end
        end
        if (reseed) begin
            next_st.long_term_average = next_st.counts;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= CHAN_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prox_cfg = st.prox_cfg;
    assign touch_cfg = st.touch_cfg;
    assign counts = st.counts;
    assign long_term_average = st.long_term_average;
    assign near = st.near;
    assign contact = st.contact;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    first_clamp_a: assert property (sample_valid && !st.primed && !st.prox_cfg[PROX_LIN_BIT]
        |=> st.counts <= $past(max_count)) else $error("first count above the limit");
    lta_frozen_a: assert property ((st.near || st.contact) && !reseed
        && (expiry_off || evt_timeout == 16'h0000) |=> $stable(st.long_term_average))
        else $error("reference moved during an event");
    event_expiry_a: assert property (sample_valid && st.primed && expire
        |=> !st.near && !st.contact && st.long_term_average == $past(filt))
        else $error("event did not expire");
    per_sample_a: assert property (!sample_valid |=> $stable(st.counts)
        && $stable(st.db_cnt) && $stable(st.ev_cnt) && $stable(st.near) && $stable(st.contact))
        else $error("channel state moved without a conversion");
    cover property (!st.near ##1 st.near);

endmodule
`default_nettype wire

// ---- tcspl_top.sv ----
// Channel state and power-mode logic of a touch and proximity sensing controller.
// Assumes an APB master, a front end pulsing conv_valid per conversion, and a host
// that raises force_comm_req before waking the device from halt.
//
// What this block does
// - Halt mode: no conversions, no processing.
// - Current power mode readable in status.
// - Host writes power mode field; device adopts it.
// - Automatic: step down after idle timeout.
// - Zero timeout: never step down.
// - Automatic without deepest mode never enters it.
// - In automatic modes, any event returns to full rate mode.
// - Linearised counts are inverted; host sets inversion.
// - Counts limited to the maximum count.
// - Linearisation applied after the limit.
// - Reference frozen during events, tracks otherwise.
// - Reseed loads reference, bit self-clears.
// - Filters damp by beta over 256.
// - Full rate betas, else reduced rate betas.
// - Fast reference betas when counts pass the fast band opposite the event direction.
// - Near state with enter and exit debounce.
// - Contact state with threshold and hysteresis.
// - State flags set while in state.
// - Inversion flips comparison sign.
// - Dual direction triggers either way.
// - Event timeout reseeds unless expiry disabled.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tcspl_top
    import tcspl_pkg::*;
#(
    parameter int NCH = 3,
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_valid,
    input wire logic [1:0] conv_channel,
    input wire logic [15:0] conv_raw,
    input wire logic force_comm_req,
    output logic sensing_enable,
    output logic [1:0] current_mode
);

    ////////////////////////////////////////////////////////////////////////////////////
    // Channel instances.

    tcspl_top_t st;
    tcspl_top_t next_st;

    logic [MAX_CH-1:0] ch_near;
    logic [MAX_CH-1:0] ch_contact;
    logic [MAX_CH-1:0] ch_sample;
    logic [MAX_CH-1:0] wr_prox;
    logic [MAX_CH-1:0] wr_touch;
    logic [26:0] ch_prox [MAX_CH];
    logic [23:0] ch_touch [MAX_CH];
    logic [15:0] ch_counts [MAX_CH];
    logic [15:0] ch_lta [MAX_CH];
    logic low_rate;

    assign low_rate = (st.cur != CUR_FULL);

    genvar g;
    generate
        for (g = 0; g < MAX_CH; g++) begin : gen_ch
            if (g < NCH) begin : gen_on
                tcspl_chan u_chan (
                    .pclk(pclk),
                    .presetn(presetn),
                    .sample_valid(ch_sample[g]),
                    .raw(conv_raw),
                    .wr_prox(wr_prox[g]),
                    .wr_touch(wr_touch[g]),
                    .wdata(pwdata),
                    .low_rate(low_rate),
                    .betas(st.betas),
                    .fast_betas(st.fast_betas),
                    .max_count(st.max_count),
                    .fast_band(st.fast_band),
                    .evt_timeout(st.evt_timeout),
                    .expiry_off(st.expiry_off[g]),
                    .reseed(st.reseed),
                    .prox_cfg(ch_prox[g]),
                    .touch_cfg(ch_touch[g]),
                    .counts(ch_counts[g]),
                    .long_term_average(ch_lta[g]),
                    .near(ch_near[g]),
                    .contact(ch_contact[g])
                );
            end else begin : gen_off
                assign ch_prox[g] = '0;
                assign ch_touch[g] = '0;
                assign ch_counts[g] = '0;
                assign ch_lta[g] = '0;
                assign ch_near[g] = 1'b0;
                assign ch_contact[g] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////
    // Bus decode and read data.

    logic setup;
    logic wr;
    logic hit;
    logic [31:0] rd;
    logic event_any;
    logic tick;
    logic mode_ok;
    tcspl_sel_t wsel;

    assign setup = psel && !penable;
    assign wr = psel && penable && st.pready && pwrite && !st.pslverr;
    assign event_any = |(ch_near | ch_contact);
    assign tick = (st.tick_cnt == 32'(TICK_CYCLES - 1));
    assign wsel = tcspl_sel_t'(pwdata[CTRL_MODE_LSB +: 3]);

    always_comb begin
        rd = '0;
        hit = 1'b1;
        unique case (paddr)
            ADDR_CTRL: begin
                rd[CTRL_MODE_LSB +: 3] = st.sel;
                rd[CTRL_RESEED_BIT] = st.reseed;
                rd[CTRL_EXPIRY_LSB +: MAX_CH] = st.expiry_off;
            end
            ADDR_STATUS: begin
                rd[STATUS_MODE_LSB +: 2] = st.cur;
                rd[STATUS_NEAR_LSB +: MAX_CH] = ch_near;
                rd[STATUS_CONTACT_LSB +: MAX_CH] = ch_contact;
            end
            ADDR_PM_TIMEOUT: rd[7:0] = st.pm_timeout;
            ADDR_EVT_TIMEOUT: rd[15:0] = st.evt_timeout;
            ADDR_BETAS: rd = st.betas;
            ADDR_FAST_BETAS: rd[15:0] = st.fast_betas;
            ADDR_MAX_COUNT: rd[15:0] = st.max_count;
            ADDR_FAST_BAND: rd[15:0] = st.fast_band;
            default: hit = 1'b0;
        endcase
        for (int c = 0; c < NCH; c++) begin
            if (paddr == ADDR_PROX_BASE + 8'(c * PROX_STRIDE)) begin
                rd = {5'b0, ch_prox[c]};
                hit = 1'b1;
            end
            if (paddr == ADDR_TOUCH_BASE + 8'(c * PROX_STRIDE)) begin
                rd = {8'b0, ch_touch[c]};
                hit = 1'b1;
            end
            if (paddr == ADDR_DATA_BASE + 8'(c * DATA_STRIDE)) begin
                rd = {ch_lta[c], ch_counts[c]};
                hit = 1'b1;
            end
        end
    end

    always_comb begin
        wr_prox = '0;
        wr_touch = '0;
        ch_sample = '0;
        for (int c = 0; c < NCH; c++) begin
            wr_prox[c] = wr && (paddr == ADDR_PROX_BASE + 8'(c * PROX_STRIDE));
            wr_touch[c] = wr && (paddr == ADDR_TOUCH_BASE + 8'(c * PROX_STRIDE));
            ch_sample[c] = conv_valid && (st.cur != CUR_HALT)
                           && (conv_channel == 2'(c));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Register writes and power-mode sequencing.

    always_comb begin
        next_st = st;
        next_st.pready = setup;
        next_st.pslverr = setup && !hit;
        if (setup) begin
            next_st.prdata = hit ? rd : 32'h00000000;
        end
        mode_ok = (st.cur != CUR_HALT) || st.halt_window;
        next_st.reseed = 1'b0;
        if (wr) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    if (mode_ok && pwdata[CTRL_MODE_LSB +: 3] <= 3'h5) begin
                        next_st.sel = wsel;
                    end
                    next_st.halt_window = 1'b0;
                    next_st.reseed = pwdata[CTRL_RESEED_BIT];
                    next_st.expiry_off = pwdata[CTRL_EXPIRY_LSB +: MAX_CH];
                end
                ADDR_PM_TIMEOUT: next_st.pm_timeout = pwdata[7:0];
                ADDR_EVT_TIMEOUT: next_st.evt_timeout = pwdata[15:0];
                ADDR_BETAS: next_st.betas = pwdata;
                ADDR_FAST_BETAS: next_st.fast_betas = pwdata[15:0];
                ADDR_MAX_COUNT: next_st.max_count = pwdata[15:0];
                ADDR_FAST_BAND: next_st.fast_band = pwdata[15:0];
                default: ;
            endcase
        end
        if (force_comm_req && st.cur == CUR_HALT) begin
            next_st.halt_window = 1'b1;
        end
        next_st.tick_cnt = tick ? 32'h00000000 : st.tick_cnt + 32'h00000001;
        unique case (st.sel)
            SEL_FULL: next_st.cur = CUR_FULL;
            SEL_REDUCED: next_st.cur = CUR_REDUCED;
            SEL_DEEPEST: next_st.cur = CUR_DEEPEST;
            SEL_HALT: next_st.cur = CUR_HALT;
            SEL_AUTO, SEL_AUTO_NO_DEEPEST: begin
                if (event_any || st.cur == CUR_HALT) begin
                    next_st.cur = CUR_FULL;
                    next_st.idle_ticks = '0;
                end else if (st.sel == SEL_AUTO_NO_DEEPEST && st.cur == CUR_DEEPEST) begin
                    next_st.cur = CUR_REDUCED;
                end else if (tick && st.pm_timeout != 8'h00) begin
                    next_st.idle_ticks = st.idle_ticks + 8'h01;
                    if (st.idle_ticks + 8'h01 >= st.pm_timeout) begin
                        next_st.idle_ticks = '0;
                        if (st.cur == CUR_FULL) begin
                            next_st.cur = CUR_REDUCED;
                        end else if (st.sel == SEL_AUTO) begin
                            next_st.cur = CUR_DEEPEST;
                        end
                    end
                end
            end
            default: next_st.cur = CUR_FULL;
        endcase
        if (st.sel != SEL_AUTO && st.sel != SEL_AUTO_NO_DEEPEST) begin
            next_st.idle_ticks = '0;
        end
        next_st.sensing_enable = (next_st.cur != CUR_HALT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= TOP_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign sensing_enable = st.sensing_enable;
    assign current_mode = st.cur;

    ////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    halt_no_sense_a: assert property (st.cur == CUR_HALT |-> !sensing_enable)
        else $error("sensing enabled in halt");
    halt_no_proc_a: assert property (st.cur == CUR_HALT && !st.reseed
        |=> $stable(ch_counts[0]) && $stable(ch_near)) else $error("processing in halt");
    status_mode_a: assert property (setup && paddr == ADDR_STATUS
        |=> prdata[1:0] == $past(st.cur) && pready) else $error("status mode wrong");
    mode_adopt_a: assert property (wr && paddr == ADDR_CTRL && st.cur != CUR_HALT
        && pwdata[2:0] == 3'h1 |-> ##2 st.cur == CUR_REDUCED)
        else $error("written mode not adopted");
    no_step_zero_a: assert property ((st.sel == SEL_AUTO || st.sel == SEL_AUTO_NO_DEEPEST)
        && st.pm_timeout == 8'h00 && st.cur == CUR_FULL |=> st.cur == CUR_FULL)
        else $error("stepped down with zero timeout");
    no_deepest_a: assert property (st.sel == SEL_AUTO_NO_DEEPEST
        |=> st.cur != CUR_DEEPEST) else $error("deepest mode entered");
    event_full_a: assert property ((st.sel == SEL_AUTO || st.sel == SEL_AUTO_NO_DEEPEST)
        && event_any |=> st.cur == CUR_FULL) else $error("event did not restore full rate");
    step_tick_a: assert property (st.cur == CUR_FULL && st.sel == SEL_AUTO
        ##1 st.cur == CUR_REDUCED |-> $past(tick)) else $error("step without idle expiry");
    reseed_clear_a: assert property (st.reseed && !(wr && paddr == ADDR_CTRL)
        |=> !st.reseed) else $error("reseed bit stuck");
    reseed_load_a: assert property (st.reseed && !ch_sample[0]
        |=> ch_lta[0] == $past(ch_counts[0])) else $error("reseed did not load reference");
    flag_status_a: assert property (setup && paddr == ADDR_STATUS
        |=> prdata[STATUS_NEAR_LSB] == $past(ch_near[0])
        && prdata[STATUS_CONTACT_LSB] == $past(ch_contact[0])) else $error("flag not shown");

    cover property (st.cur == CUR_FULL ##1 st.cur == CUR_REDUCED);
    cover property (st.cur == CUR_REDUCED ##1 st.cur == CUR_DEEPEST);
    cover property (st.cur == CUR_HALT && st.halt_window ##1 st.cur == CUR_HALT ##1
        st.cur != CUR_HALT);
    cover property (st.reseed);

endmodule
`default_nettype wire

// ---- tcspl_host.sv ----
// APB master standing in for the host controller.
// Assumes a slave on pclk that may add wait states.
`timescale 1ns/1ps
`default_nettype none
module tcspl_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [7:0] paddr,
    output var logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Mode writes and wake-up writes go through this one transfer.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench of the channel state and power logic.
// Assumes the host model drives APB and the bench drives conversions.
`timescale 1ns/1ps
`default_nettype none
module tb_top import tcspl_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, conv_valid = 1'b0, force_comm_req = 1'b0;
    logic psel, penable, pwrite, pready, sensing_enable, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, p;
    logic [15:0] conv_raw = 16'h0000, lo;
    logic [1:0] current_mode, conv_ch = 2'h0;
    int fails = 0, compares = 0;
    integer seed;
    always #25 pclk = ~pclk;
    tcspl_top #(.NCH(3), .TICK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid), .conv_channel(conv_ch),
        .conv_raw(conv_raw), .force_comm_req(force_comm_req),
        .sensing_enable(sensing_enable), .current_mode(current_mode));
    tcspl_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h got %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        logic [31:0] r;
        host.xfer(1'b0, a, 32'h0, r);
        chk(n, e, r & m);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, d, r);
    endtask
    task automatic conv(input logic [15:0] r, input int n);
        repeat (n) begin
            @(posedge pclk);
            conv_valid <= 1'b1;
            conv_raw <= r;
            @(posedge pclk);
            conv_valid <= 1'b0;
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        fails++;
        wrap_up();
    end
    initial begin
        seed = 48;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk("betas", ADDR_BETAS, '1, BETAS_RST);
        for (int m = 2; m >= 0; m--) begin
            wr(ADDR_CTRL, 32'(m));
            repeat (3) @(posedge pclk);
            rchk("mode", ADDR_STATUS, 32'h3, 32'(m));
        end
        wr(ADDR_CTRL, 32'h3);
        repeat (3) @(posedge pclk);
        chk("enable", 32'h0, {31'h0, sensing_enable});
        conv(16'h0100, 2);
        wr(ADDR_CTRL, 32'h0);
        rchk("halt held", ADDR_STATUS, 32'h3, 32'h3);
        @(posedge pclk);
        force_comm_req <= 1'b1;
        @(posedge pclk);
        force_comm_req <= 1'b0;
        wr(ADDR_CTRL, 32'h0);
        repeat (3) @(posedge pclk);
        rchk("woken", ADDR_STATUS, 32'h3, 32'h0);
        wr(ADDR_MAX_COUNT, 32'h1000);
        conv(16'h1000 | 16'($random(seed)), 1);
        rchk("clamp", ADDR_DATA_BASE, '1, 32'h10001000);
        lo = {8'h08, 8'($random(seed))};
        conv(lo, 1);
        rchk("contact", ADDR_STATUS, 32'h1100, 32'h1000);
        conv(lo, 2);
        rchk("near", ADDR_STATUS, 32'h1100, 32'h1100);
        host.xfer(1'b0, ADDR_DATA_BASE, 32'h0, q);
        conv(lo, 2);
        host.xfer(1'b0, ADDR_DATA_BASE, 32'h0, p);
        chk("frozen", q & 32'hffff0000, p & 32'hffff0000);
        wr(ADDR_CTRL, 32'h8);
        rchk("reseed", ADDR_DATA_BASE, '1, {p[15:0], p[15:0]});
        rchk("self clear", ADDR_CTRL, 32'h8, 32'h0);
        wr(ADDR_PM_TIMEOUT, 32'h1);
        wr(ADDR_CTRL, 32'h4);
        conv(16'h1000, 6);
        repeat (40) @(posedge pclk);
        chk("auto", 32'h2, {30'h0, current_mode});
        wr(ADDR_CTRL, 32'h5);
        repeat (40) @(posedge pclk);
        chk("no deepest", 32'h1, {30'h0, current_mode});
        conv(lo, 1);
        repeat (2) @(posedge pclk);
        chk("event", 32'h0, {30'h0, current_mode});
        wr(ADDR_PM_TIMEOUT, 32'h0);
        conv(16'h1000, 6);
        repeat (40) @(posedge pclk);
        chk("no step", 32'h0, {30'h0, current_mode});
        rchk("unmapped", 8'h20, '1, 32'h0);
        chk("pslverr", 32'h1, {31'h0, pslverr});
        wr(ADDR_PROX_BASE + 8'h08, 32'h03000020);
        conv_ch <= 2'h1;
        conv(16'hffff, 1);
        rchk("linearised", ADDR_DATA_BASE + 8'h04, '1, 32'hefffefff);
        conv(16'h0800, 1);
        rchk("inverted", ADDR_STATUS, 32'h2200, 32'h2200);
        wr(ADDR_EVT_TIMEOUT, 32'h2);
        conv(16'h0800, 2);
        rchk("expired", ADDR_STATUS, 32'h2200, 32'h0);
        rchk("expiry lta", ADDR_DATA_BASE + 8'h04, '1, 32'hf6fff6ff);
        wr(ADDR_PROX_BASE + 8'h10, 32'h04000020);
        conv_ch <= 2'h2;
        conv(16'h0800, 1);
        conv(16'h0c00, 1);
        rchk("dual", ADDR_STATUS, 32'h4400, 32'h4400);
        wrap_up();
    end
endmodule
`default_nettype wire
